// ==== pwc_pkg.sv ====
package pwc_pkg;

    // register map (byte addresses)
    localparam logic [7:0] PWC_CTL_OFFSET     = 8'h20;
    localparam logic [7:0] PWC_IRQ_STS_OFFSET = 8'h40;
    localparam logic [7:0] PWC_IRQ_EN_OFFSET  = 8'h44;
    localparam logic [7:0] PWC_IRQ_CLR_OFFSET = 8'h48;

    // control register fields
    localparam int PWC_WAKEUP_CAUSE_STATUS_LSB   = 0;
    localparam int PWC_ENERGY_DETECT_WAKE_ENABLE_BIT  = 2;
    localparam int PWC_LAN_WAKE_ENABLE_BIT = 3;
    localparam int PWC_PHYRST_BIT = 4;
    localparam int PWC_RESCLR_BIT = 8;

    // reset values
    localparam logic       PWC_PHYRST_RESET = 1'h0;
    localparam logic       PWC_WAKE_EN_RESET = 1'h0;
    localparam logic [1:0] PWC_WAKEUP_CAUSE_STATUS_RESET   = 2'h0;
    localparam logic       PWC_RESCLR_RESET = 1'h1;
    localparam logic [2:0] PWC_IRQ_RESET    = 3'h0;

    // interrupt status bits
    localparam int PWC_IRQ_ED_BIT     = 0;
    localparam int PWC_IRQ_LAN_BIT    = 1;
    localparam int PWC_IRQ_RSTDONE_BIT = 2;

    // timing
    localparam int PWC_CLOCK_HZ     = 20000000;
    localparam int PWC_PHY_RST_US   = 2000;
    localparam int PWC_PHY_RST_CYC  = (PWC_PHY_RST_US * (PWC_CLOCK_HZ / 1000000));
    localparam int PWC_CNT_W        = 16;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } pwc_bus_req_type;

    typedef struct packed {
        logic        edWake;
        logic        lanWake;
        logic        goodFrameWake;
        logic        remoteResumeDone;
        logic        hostResumeDone;
    } pwc_wake_evt_type;

endpackage

// ==== pwc_phy_reset_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwc_phy_reset_timer
    import pwc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    logic [PWC_CNT_W-1:0] count_reg;

    // counts out the minimum hold; start ignored while busy
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy      <= 1'b0;
            done      <= 1'b0;
            count_reg <= '0;
        end else begin
            done <= 1'b0;
            if (!busy && start) begin
                busy      <= 1'b1;
                count_reg <= PWC_CNT_W'(PWC_PHY_RST_CYC - 1);
            end else if (busy) begin
                if (count_reg == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_reg <= count_reg - 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== pwc_irq_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwc_irq_ctrl
    import pwc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [2:0] events,
    input  wire logic       enWrite,
    input  wire logic       clrWrite,
    input  wire logic [2:0] wdata,
    output logic [2:0]      status,
    output logic [2:0]      enable,
    output logic            irq
);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            enable <= PWC_IRQ_RESET;
        end else if (enWrite) begin
            enable <= wdata;
        end
    end

    // set beats a clear in the same cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            status <= PWC_IRQ_RESET;
        end else begin
            status <= (status & ~(clrWrite ? wdata : 3'h0)) | events;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & enable);
        end
    end

endmodule
`default_nettype wire

// ==== pwc_power_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwc_power_control
    import pwc_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [7:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [3:0]       avs_byteenable,
    input  wire logic [31:0]      avs_writedata,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    input  wire pwc_wake_evt_type wakeEvents,
    input  wire logic             suspendEnter,
    output logic                  phyReset,
    output logic                  usbNakAll,
    output logic                  lanWakeArmed,
    output logic                  energyDetectArmed,
    output logic                  irq
);

    ////////////////////////////////////////////////////////////////////////
    // bus front end: one wait cycle, then the access completes

    pwc_bus_req_type req;
    logic            ackPending_reg;
    logic            accept;
    logic            wrCtl;
    logic            wrEn;
    logic            wrClr;
    logic [31:0]     wd;

    assign req    = '{read: avs_read, write: avs_write, address: avs_address,
                      writedata: avs_writedata};
    assign accept = ackPending_reg && (req.read || req.write);
    assign wd     = req.writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    assign wrCtl = accept && req.write && hit(req.address, PWC_CTL_OFFSET);
    assign wrEn  = accept && req.write && hit(req.address, PWC_IRQ_EN_OFFSET);
    assign wrClr = accept && req.write && hit(req.address, PWC_IRQ_CLR_OFFSET);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ackPending_reg <= 1'b0;
        end else begin
            ackPending_reg <= (req.read || req.write) && !ackPending_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((req.read || req.write) && !ackPending_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PHY reset

    logic phyRst_reg;
    logic rstStart;
    logic rstBusy;
    logic rstDone;

    assign rstStart = wrCtl && wd[PWC_PHYRST_BIT] && !phyRst_reg;

    pwc_phy_reset_timer u_timer (
        .clock (clock),
        .rst_b (rst_b),
        .start (rstStart),
        .busy  (rstBusy),
        .done  (rstDone)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phyRst_reg <= PWC_PHYRST_RESET;
        end else if (rstStart) begin
            phyRst_reg <= 1'b1;
        end else if (rstDone) begin
            phyRst_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phyReset  <= 1'b0;
            usbNakAll <= 1'b0;
        end else begin
            phyReset  <= rstStart || (rstBusy && !rstDone);
            usbNakAll <= rstStart || (rstBusy && !rstDone);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake enables, auto-clear control and cause status

    logic       lanEn_reg;
    logic       edEn_reg;
    logic       resClr_reg;
    logic       lanArmed_reg;
    logic       edArmed_reg;
    logic [1:0] wakeup_cause_status_reg;
    logic [1:0] wupsSet;
    logic [1:0] wupsClr;
    logic       autoClear;

    assign autoClear = wakeEvents.remoteResumeDone && resClr_reg;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            resClr_reg <= PWC_RESCLR_RESET;
        end else if (wrCtl) begin
            resClr_reg <= wd[PWC_RESCLR_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lanEn_reg <= PWC_WAKE_EN_RESET;
        end else if (autoClear) begin
            lanEn_reg <= 1'b0;
        end else if (wrCtl) begin
            lanEn_reg <= wd[PWC_LAN_WAKE_ENABLE_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            edEn_reg <= PWC_WAKE_EN_RESET;
        end else if (autoClear) begin
            edEn_reg <= 1'b0;
        end else if (wrCtl) begin
            edEn_reg <= wd[PWC_ENERGY_DETECT_WAKE_ENABLE_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lanArmed_reg <= 1'b0;
            edArmed_reg  <= 1'b0;
        end else if (suspendEnter) begin
            lanArmed_reg <= lanEn_reg;
            edArmed_reg  <= edEn_reg;
        end
    end

    // bit 0 energy detect, bit 1 LAN or good frame
    assign wupsSet[0] = wakeEvents.edWake && edArmed_reg;
    assign wupsSet[1] = (wakeEvents.lanWake || wakeEvents.goodFrameWake) && lanArmed_reg;
    assign wupsClr    = wrCtl ? wd[PWC_WAKEUP_CAUSE_STATUS_LSB +: 2] : 2'h0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wakeup_cause_status_reg <= PWC_WAKEUP_CAUSE_STATUS_RESET;
        end else begin
            wakeup_cause_status_reg <= (wakeup_cause_status_reg & ~wupsClr) | wupsSet;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lanWakeArmed      <= 1'b0;
            energyDetectArmed <= 1'b0;
        end else begin
            lanWakeArmed      <= lanArmed_reg;
            energyDetectArmed <= edArmed_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: energy wake, LAN wake, PHY reset done

    logic [2:0] irqSts;
    logic [2:0] irqEn;

    pwc_irq_ctrl u_irq (
        .clock    (clock),
        .rst_b    (rst_b),
        .events   ({rstDone, wupsSet[1], wupsSet[0]}),
        .enWrite  (wrEn),
        .clrWrite (wrClr),
        .wdata    (wd[2:0]),
        .status   (irqSts),
        .enable   (irqEn),
        .irq      (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // read data

    logic [31:0] rdNext;

    always_comb begin
        rdNext = 32'h0;
        case (req.address)
            PWC_CTL_OFFSET: begin
                rdNext[PWC_WAKEUP_CAUSE_STATUS_LSB +: 2] = wakeup_cause_status_reg;
                rdNext[PWC_ENERGY_DETECT_WAKE_ENABLE_BIT]     = edEn_reg;
                rdNext[PWC_LAN_WAKE_ENABLE_BIT]    = lanEn_reg;
                rdNext[PWC_PHYRST_BIT]    = phyRst_reg;
                rdNext[PWC_RESCLR_BIT]    = resClr_reg;
            end
            PWC_IRQ_STS_OFFSET: rdNext[2:0] = irqSts;
            PWC_IRQ_EN_OFFSET:  rdNext[2:0] = irqEn;
            default:            rdNext = 32'h0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0;
        end else if ((req.read || req.write) && !ackPending_reg) begin
            avs_readdata <= rdNext;
        end
    end

endmodule
`default_nettype wire

// ==== pwc_power_control_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwc_power_control_chk
    import pwc_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        suspendEnter,
    input wire logic        phyReset,
    input wire logic        usbNakAll,
    input wire logic        lanWakeArmed
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic        rstWr_reg;
    logic [16:0] held_reg;
    // write to the reset bit, seen one edge late when it takes effect
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstWr_reg <= 1'h0;
            held_reg <= 17'h0;
        end else begin
            rstWr_reg <= avs_write && !avs_waitrequest && avs_address == PWC_CTL_OFFSET
                && avs_byteenable[0] && avs_writedata[PWC_PHYRST_BIT];
            held_reg <= phyReset ? held_reg + 17'h1 : 17'h0;
        end
    end
    ////////////////////////////////////////
    a_nak_tracks_reset: assert property (usbNakAll == phyReset)
        else $error("nak differs from phy reset");
    a_reset_starts: assert property (rstWr_reg && !$past(phyReset) |-> phyReset)
        else $error("phy reset not started");
    a_reset_cause: assert property ($rose(phyReset) |-> rstWr_reg)
        else $error("phy reset without write");
    a_reset_min_hold: assert property ($fell(phyReset) |-> held_reg >= PWC_PHY_RST_CYC)
        else $error("phy reset too short");
    a_reset_self_ends: assert property (held_reg <= PWC_PHY_RST_CYC + 2)
        else $error("phy reset never ends");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    a_wait_answers: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus not answered");
    a_arm_on_suspend: assert property ($rose(lanWakeArmed) |-> $past(suspendEnter, 2))
        else $error("armed without suspend");
    cover property ($fell(phyReset));
    cover property ($rose(lanWakeArmed));
    cover property (avs_read && !avs_waitrequest);
endmodule
`default_nettype wire

// ==== pwc_wake_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwc_wake_model
    import pwc_pkg::*;
(
    input wire logic            clock,
    input wire logic            rst_b,
    input wire logic            go,
    input wire logic [5:0]      pattern,
    input wire logic [3:0]      delay,
    output var pwc_wake_evt_type wakeEvents,
    output logic                suspendEnter,
    output logic                busy
);
    logic [5:0] pat_reg;
    logic [3:0] cnt_reg;
    // single-cycle pulses; a delay mimics a slow phy or resume path
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'h0;
            pat_reg <= 6'h0;
            cnt_reg <= 4'h0;
            {suspendEnter, wakeEvents} <= 6'h0;
        end else begin
            {suspendEnter, wakeEvents} <= 6'h0;
            if (go) begin
                busy <= 1'h1;
                pat_reg <= pattern;
                cnt_reg <= delay;
            end else if (busy && cnt_reg != 4'h0) begin
                cnt_reg <= cnt_reg - 4'h1;
            end else if (busy) begin
                busy <= 1'h0;
                {suspendEnter, wakeEvents} <= pat_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ==== pwc_power_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwc_power_control_tb_top
    import pwc_pkg::*;
;
    logic             clock;
    logic             rst_b;
    logic [7:0]       addr;
    logic             rd;
    logic             wr;
    logic [31:0]      wdata;
    logic [31:0]      rdata;
    logic             waitReq;
    logic             go;
    logic [5:0]       pat;
    logic [3:0]       dly;
    logic             mBusy;
    pwc_wake_evt_type evts;
    logic             susp;
    logic             phyRst;
    logic             nak;
    logic             lanArm;
    logic             edArm;
    logic             irq;
    logic [15:0]      lfsr;
    logic [31:0]      got;
    int               error_cnt;
    int               compares;
    int               cycles;
    int               t0;
    pwc_power_control DUT (.clock(clock), .rst_b(rst_b), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_byteenable(4'hF), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(waitReq), .wakeEvents(evts), .suspendEnter(susp), .phyReset(phyRst),
        .usbNakAll(nak), .lanWakeArmed(lanArm), .energyDetectArmed(edArm), .irq(irq));
    pwc_wake_model wake (.clock(clock), .rst_b(rst_b), .go(go), .pattern(pat), .delay(dly),
        .wakeEvents(evts), .suspendEnter(susp), .busy(mBusy));
    ////////////////////////////////////////
    function automatic logic [15:0] nextRnd(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] cv(input logic rc, phy, lan, ed, input logic [1:0] c);
        return {23'h0, rc, 3'h0, phy, lan, ed, c};
    endfunction
    task automatic final_report;
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // the global timeout bounds the wait for the slave
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        do @(posedge clock); while (waitReq);
        got = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task automatic rdc(input logic [31:0] e, input logic [7:0] a = PWC_CTL_OFFSET);
        bus(1'h0, a, 32'h0);
        cmp("readdata", e, got);
    endtask
    // bits 31:9 get random junk so decode slips show up
    task automatic wrc(input logic [8:0] b);
        lfsr = nextRnd(lfsr);
        bus(1'h1, PWC_CTL_OFFSET, {lfsr, lfsr[15:9], b});
    endtask
    task automatic fire(input logic [5:0] p, input logic [3:0] d);
        @(posedge clock);
        go <= 1'h1;
        pat <= p;
        dly <= d;
        @(posedge clock);
        go <= 1'h0;
        do @(posedge clock); while (mBusy);
        repeat (2) @(posedge clock);
    endtask
    ////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        {rst_b, rd, wr, go, addr, wdata, pat, dly} = '0;
        {error_cnt, compares, cycles} = '0;
        lfsr = 16'hDDEE;
        repeat (8) @(posedge clock);
        rst_b <= 1'h1;
        rdc(cv(1, 0, 0, 0, 2'h0));
        wrc(9'h10C);
        bus(1'h1, PWC_IRQ_EN_OFFSET, 32'h7);
        fire(6'h20, 4'h0);
        cmp("armed", 32'h3, {edArm, lanArm});
        fire(6'h18, lfsr[3:0]);
        rdc(cv(1, 0, 1, 1, 2'h3));
        rdc(32'h3, PWC_IRQ_STS_OFFSET);
        cmp("irq", 32'h1, irq);
        wrc(9'h10D);
        rdc(cv(1, 0, 1, 1, 2'h2));
        wrc(9'h10C);
        rdc(cv(1, 0, 1, 1, 2'h2));
        wrc(9'h10E);
        rdc(cv(1, 0, 1, 1, 2'h0));
        bus(1'h1, PWC_IRQ_CLR_OFFSET, 32'h3);
        rdc(32'h0, PWC_IRQ_STS_OFFSET);
        cmp("irq", 32'h0, irq);
        fire(6'h04, 4'h0);
        fire(6'h01, 4'h2);
        rdc(cv(1, 0, 1, 1, 2'h2));
        fire(6'h02, 4'h0);
        rdc(cv(1, 0, 0, 0, 2'h2));
        wrc(9'h102);
        fire(6'h20, 4'h0);
        fire(6'h18, 4'h0);
        rdc(cv(1, 0, 0, 0, 2'h0));
        wrc(9'h00C);
        fire(6'h02, 4'h0);
        rdc(cv(0, 0, 1, 1, 2'h0));
        bus(1'h1, 8'h30, {lfsr, lfsr});
        rdc(32'h0, 8'h30);
        wrc(9'h01C);
        t0 = cycles;
        rdc(cv(0, 1, 1, 1, 2'h0));
        cmp("nak", 32'h1, nak);
        wrc(9'h00C);
        rdc(cv(0, 1, 1, 1, 2'h0));
        while (phyRst) @(posedge clock);
        cmp("hold", 32'h1, cycles - t0 >= PWC_PHY_RST_CYC - 1);
        rdc(cv(0, 0, 1, 1, 2'h0));
        cmp("nak", 32'h0, nak);
        // reset-done event plus the earlier good-frame cause still pending
        rdc(32'h6, PWC_IRQ_STS_OFFSET);
        cmp("irq", 32'h1, irq);
        rst_b <= 1'h0;
        @(posedge clock);
        rst_b <= 1'h1;
        rdc(cv(1, 0, 0, 0, 2'h0));
        final_report();
    end
endmodule
bind pwc_power_control pwc_power_control_chk chk (.clock(clock), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .suspendEnter(suspendEnter), .phyReset(phyReset),
    .usbNakAll(usbNakAll), .lanWakeArmed(lanWakeArmed));
`default_nettype wire
